// ---- core/anc_ctrl.sv ----
// negotiation control, mdio register slave and address/led straps
// assumes line-side receivers report link and page events on sys_clk;
// mdc and mdio_in are raw pins and are synchronised here
// Notes on behaviour
// - while enabled, bursts carry the current local advertisement value
// - speed/duplex summary bits valid only when disabled or complete
// - resolve priority: 100 full, 100 half, 10 full, 10 half
// - basic control enables, disables and restarts negotiation
// - with negotiation off, speed and duplex bits set the mode
// - with negotiation on, speed and duplex bits are ignored
// - status ability bits are constant ones, 100BASE-T4 reads zero
// - advertisement resets to all abilities; cleared bits leave bursts
// - partner register takes pages; parallel detect loads 0081h/0021h
// - expansion reports fault, next-page support, page received, able
// - parallel detect picks the technology whose link alone is good
// - parallel detect sets bit 5 or 7 and selector 00001
// - after parallel detect, partner-able reads zero, complete reads one
// - both links good at once sets the fault bit; no good link leaves it
// - writing restart after completion begins a fresh negotiation
// - loss of a negotiated link resumes negotiation
// - restart or enable silences pulses for the break timer, then bursts
// - from a forced reset, enable must be set, cleared, then set again
// - answers on one of 32 addresses chosen by straps
// - address straps latched into transceiver control bits 4:0
// - straps share duplex, col, link, tx, rx leds; speed has none
// - led drives high if strap low, low if strap high
// - enable and advert straps set advertisement bits 8:5
// - strapped address zero isolates; written zero does not
`include "anc_regs.svh"
module anc_ctrl #(
    parameter int BREAK_CYC = `ANC_BREAK_MS * `ANC_CLK_KHZ
) (
    input wire logic sys_clk, // 125 MHz
    input wire logic sys_rst, // async, active high
    input wire logic [4:0] address_strap, // strap pins, sampled at release
    input wire logic negotiation_enable_strap, // strap pin
    input wire logic advert_strap_high, // strap pin
    input wire logic advert_strap_low, // strap pin
    input wire logic mdc, // management clock pin
    input wire logic mdio_in, // management data pin level
    output logic mdio_out, // management data drive value
    output logic mdio_oe, // high while driving mdio
    input wire logic link100_ok, // 100 Mb/s receiver link good
    input wire logic link10_ok, // 10 Mb/s receiver link good
    input wire logic page_rx, // pulse: partner page received
    input wire logic [15:0] page_word, // received code word
    input wire logic led_col_src, // collision activity
    input wire logic led_tx_src, // transmit activity
    input wire logic led_rx_src, // receive activity
    output logic flp_send, // pulse: send one burst
    output logic [15:0] flp_word, // code word for the burst
    output logic tx_quiet, // halt data and pulses
    output anc_pkg::anc_mode_type op_mode, // operating mode
    output logic mode_valid, // op_mode may be trusted
    output logic isolate, // strapped isolate
    output anc_pkg::anc_led_type led_out, // strap-shared led pins
    output logic led_speed // high at 100 Mb/s
);
    anc_pkg::anc_state_type st_r;
    logic [15:0] ctrl_r, adv_r, lpa_r;
    logic [4:0] addr_r;
    logic [4:0] led_pol_r;
    logic strap_done_r, forced_boot_r, an_armed_r, an_prev_r;
    logic pd_fault_r, lp_able_r, lp_np_r, page_r;
    logic [31:0] tmr_r;
    logic [2:0] mdc_s, md_s;
    logic [5:0] bitcnt_r;
    logic [31:0] sh_r;
    logic [15:0] rd_r;
    logic restart_req, wr_stb, good_link;
    anc_pkg::anc_mode_type res_mode;

    function automatic anc_pkg::anc_mode_type resolve(
        input logic [15:0] a, input logic [15:0] b);
        logic [15:0] c;
        c = a & b;
        if (c[8]) resolve = '{1'b1, 1'b1};
        else if (c[7]) resolve = '{1'b1, 1'b0};
        else if (c[6]) resolve = '{1'b0, 1'b1};
        else resolve = '{1'b0, 1'b0};
    endfunction

    // straps caught on the first clock after release, never under reset
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            strap_done_r <= 1'b0;
            addr_r <= 5'h00;
            led_pol_r <= 5'h00;
            forced_boot_r <= 1'b0;
            isolate <= 1'b0;
        end else if (!strap_done_r) begin
            strap_done_r <= 1'b1;
            addr_r <= address_strap;
            led_pol_r <= address_strap;
            forced_boot_r <= !negotiation_enable_strap;
            isolate <= (address_strap == 5'h00);
        end
    end

    // mdc and mdio pass two flops before any use
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mdc_s <= 3'h7; // idle high, so no false edge after reset
            md_s <= 3'h7;
        end else begin
            mdc_s <= {mdc_s[1:0], mdc};
            md_s <= {md_s[1:0], mdio_in};
        end
    end

    wire mdc_rise = mdc_s[1] & !mdc_s[2];
    wire mdc_fall = !mdc_s[1] & mdc_s[2];
    wire [4:0] f_phy = sh_r[26:22];
    wire [4:0] f_reg = sh_r[21:17];

    function automatic logic [15:0] reg_read(input logic [4:0] a);
        unique case (a)
            `ANC_OFS_CTRL: reg_read = ctrl_r;
            `ANC_OFS_STAT: reg_read = `ANC_STAT_CONST
                | {10'h000, st_r == anc_pkg::AN_DONE, 2'h0,
                   good_link, 2'h0};
            `ANC_OFS_ADV: reg_read = adv_r;
            `ANC_OFS_LPA: reg_read = lpa_r;
            `ANC_OFS_EXP: reg_read = {11'h000, pd_fault_r, lp_np_r,
                1'b0, page_r, lp_able_r};
            `ANC_OFS_XSTAT: reg_read = {13'h0000,
                mode_valid & op_mode.full_dup,
                mode_valid & !op_mode.speed100,
                1'b0};
            `ANC_OFS_XCTRL: reg_read = {11'h000, addr_r};
            default: reg_read = 16'h0000;
        endcase
    endfunction

    // mdio frame: preamble, 01, op, phy, reg, turnaround, 16 data bits
    // sampled on mdc rise; read data driven after mdc fall
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bitcnt_r <= 6'h00;
            sh_r <= 32'h0000_0000;
            rd_r <= 16'h0000;
            mdio_oe <= 1'b0;
            mdio_out <= 1'b0;
        end else if (mdc_rise) begin
            sh_r <= {sh_r[30:0], md_s[2]};
            if (bitcnt_r == 6'h00) begin
                if (sh_r[0] && !md_s[2]) bitcnt_r <= 6'h01;
            end else if (bitcnt_r == 6'h20) begin
                bitcnt_r <= 6'h00;
            end else begin
                bitcnt_r <= bitcnt_r + 6'h01;
            end
        end else if (mdc_fall) begin
            if (bitcnt_r == 6'h0E && sh_r[11:10] == 2'b10
                && sh_r[9:5] == addr_r) begin
                mdio_oe <= 1'b1;
                mdio_out <= 1'b0;
                rd_r <= reg_read(sh_r[4:0]);
            end else if (mdio_oe && bitcnt_r > 6'h0F
                         && bitcnt_r < 6'h20) begin
                mdio_out <= rd_r[15];
                rd_r <= {rd_r[14:0], 1'b0};
            end else if (bitcnt_r == 6'h00 || bitcnt_r == 6'h20) begin
                mdio_oe <= 1'b0;
            end
        end
    end

    // after 32 bits from the start pair, a write frame is complete
    assign wr_stb = mdc_rise && bitcnt_r == 6'h1F
        && sh_r[30:29] == 2'b01 && sh_r[28:27] == 2'b01
        && f_phy == addr_r;
    wire [15:0] wr_data = {sh_r[14:0], md_s[2]};
    wire [4:0] wr_reg = f_reg;
    wire [4:0] wr_phy = f_phy;
    wire wr_ok = wr_stb && wr_phy == addr_r;

    assign good_link = op_mode.speed100 ? link100_ok : link10_ok;

    // control and advertisement registers
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_r <= 16'h0000;
            adv_r <= 16'h01E1;
            an_prev_r <= 1'b0;
            an_armed_r <= 1'b0;
        end else begin
            an_prev_r <= ctrl_r[`ANC_B_ANEN];
            if (!strap_done_r) begin
                ctrl_r[`ANC_B_ANEN] <= negotiation_enable_strap;
                ctrl_r[`ANC_B_SPEED] <= advert_strap_high;
                ctrl_r[`ANC_B_DUPLEX] <= advert_strap_low;
                an_armed_r <= negotiation_enable_strap;
                if (negotiation_enable_strap) begin
                    unique case ({advert_strap_high, advert_strap_low})
                        2'b00: adv_r[8:5] <= 4'h3;
                        2'b01: adv_r[8:5] <= 4'hC;
                        2'b10: adv_r[8:5] <= 4'h5;
                        2'b11: adv_r[8:5] <= 4'hF;
                    endcase
                end
            end else begin
                // forced boot: clearing enable after it was set arms it
                if (an_prev_r && !ctrl_r[`ANC_B_ANEN])
                    an_armed_r <= 1'b1;
                if (restart_req)
                    ctrl_r[`ANC_B_RESTART] <= 1'b0;
                if (wr_ok && wr_reg == `ANC_OFS_CTRL)
                    ctrl_r <= wr_data;
                if (wr_ok && wr_reg == `ANC_OFS_ADV)
                    adv_r <= wr_data;
            end
        end
    end

    wire an_on = ctrl_r[`ANC_B_ANEN] && (an_armed_r || !forced_boot_r);
    assign restart_req = ctrl_r[`ANC_B_RESTART] && an_on;
    assign res_mode = resolve(adv_r, lpa_r);

    // negotiation sequencer
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= anc_pkg::AN_IDLE;
            tmr_r <= 32'h0000_0000;
            lpa_r <= 16'h0000;
            pd_fault_r <= 1'b0;
            lp_able_r <= 1'b0;
            lp_np_r <= 1'b0;
            page_r <= 1'b0;
            flp_send <= 1'b0;
            tx_quiet <= 1'b0;
            op_mode <= '{1'b0, 1'b0};
            mode_valid <= 1'b0;
        end else begin
            flp_send <= 1'b0;
            if (!an_on) begin
                st_r <= anc_pkg::AN_FORCED;
                tx_quiet <= 1'b0;
                op_mode <= '{ctrl_r[`ANC_B_SPEED],
                    ctrl_r[`ANC_B_DUPLEX]};
                mode_valid <= 1'b1;
            end else if (restart_req || st_r == anc_pkg::AN_FORCED
                         || st_r == anc_pkg::AN_IDLE) begin
                st_r <= anc_pkg::AN_BREAK;
                tmr_r <= 32'h0000_0000;
                tx_quiet <= 1'b1;
                mode_valid <= 1'b0;
            end else begin
                unique case (st_r)
                    anc_pkg::AN_BREAK: begin
                        if (tmr_r >= BREAK_CYC - 1) begin
                            st_r <= anc_pkg::AN_SEND;
                            tx_quiet <= 1'b0;
                            // first burst at once, before a fixed partner
                            // can finish parallel detection
                            tmr_r <= 32'(`ANC_BURST_CYC - 1);
                        end else tmr_r <= tmr_r + 32'h1;
                    end
                    anc_pkg::AN_SEND: begin
                        tmr_r <= tmr_r + 32'h1;
                        if (tmr_r >= `ANC_BURST_CYC - 1) begin
                            tmr_r <= 32'h0000_0000;
                            flp_send <= 1'b1;
                        end
                        if (page_rx) begin
                            lpa_r <= page_word;
                            page_r <= 1'b1;
                            lp_able_r <= 1'b1;
                            lp_np_r <= page_word[15];
                            st_r <= anc_pkg::AN_DONE;
                            op_mode <= resolve(adv_r, page_word);
                            mode_valid <= 1'b1;
                        end else if (link100_ok ^ link10_ok) begin
                            lpa_r <= link100_ok ? `ANC_LPA_PD100
                                : `ANC_LPA_PD10;
                            lp_able_r <= 1'b0;
                            st_r <= anc_pkg::AN_DONE;
                            op_mode <= '{link100_ok, 1'b0};
                            mode_valid <= 1'b1;
                        end else if (link100_ok && link10_ok) begin
                            pd_fault_r <= 1'b1;
                        end
                    end
                    anc_pkg::AN_DONE: begin
                        if (!good_link) begin
                            st_r <= anc_pkg::AN_SEND;
                            mode_valid <= 1'b0;
                            page_r <= 1'b0;
                        end
                    end
                    default: st_r <= anc_pkg::AN_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) flp_word <= 16'h0000;
        else flp_word <= adv_r;
    end

    // leds drive against their strap
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            led_out <= '0;
            led_speed <= 1'b0;
        end else begin
            led_out <= {op_mode.full_dup, led_col_src, good_link,
                led_tx_src, led_rx_src}
                ^ {led_pol_r[0], led_pol_r[1], led_pol_r[2],
                   led_pol_r[3], led_pol_r[4]};
            led_speed <= op_mode.speed100;
        end
    end

    a_fault_sets: assert property (@(posedge sys_clk) disable iff (sys_rst)
        st_r == anc_pkg::AN_SEND && an_on && !restart_req && !page_rx
        && link100_ok && link10_ok |=> pd_fault_r)
        else $error("fault not set");
    a_pd_lpa: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $rose(st_r == anc_pkg::AN_DONE) && !lp_able_r
        |-> lpa_r == 16'h0081 || lpa_r == 16'h0021)
        else $error("bad pd partner word");
    a_quiet_break: assert property (@(posedge sys_clk) disable iff (sys_rst)
        st_r == anc_pkg::AN_BREAK |-> tx_quiet && !flp_send)
        else $error("pulses during break");
    a_forced_mode: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !an_on && strap_done_r |=> op_mode.speed100
        == $past(ctrl_r[13]))
        else $error("forced speed wrong");
    a_word_adv: assert property (@(posedge sys_clk) disable iff (sys_rst)
        flp_send |-> flp_word == $past(adv_r))
        else $error("burst word stale");
    a_valid_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
        mode_valid |-> !an_on || st_r == anc_pkg::AN_DONE
        || $past(!an_on))
        else $error("mode valid too early");
    a_loss_resume: assert property (@(posedge sys_clk) disable iff (sys_rst)
        st_r == anc_pkg::AN_DONE && !good_link && an_on && !restart_req
        |=> st_r == anc_pkg::AN_SEND)
        else $error("no resume on loss");
    a_restart_brk: assert property (@(posedge sys_clk) disable iff (sys_rst)
        restart_req |=> st_r == anc_pkg::AN_BREAK ##1
        !ctrl_r[9])
        else $error("restart ignored");
    c_pd_done: cover property (@(posedge sys_clk)
        st_r == anc_pkg::AN_DONE && !lp_able_r);
    c_page_done: cover property (@(posedge sys_clk)
        st_r == anc_pkg::AN_DONE && lp_able_r);
    c_restart: cover property (@(posedge sys_clk) restart_req);
endmodule

// ---- core/anc_regs.svh ----
// register offsets, field positions, reset values and timing counts
// assumes a 125 MHz sys_clk and an mdc sampled as a plain pin
`ifndef ANC_REGS_SVH
`define ANC_REGS_SVH
`define ANC_OFS_CTRL 5'h00
`define ANC_OFS_STAT 5'h01
`define ANC_OFS_ADV 5'h04
`define ANC_OFS_LPA 5'h05
`define ANC_OFS_EXP 5'h06
`define ANC_OFS_XSTAT 5'h10
`define ANC_OFS_XCTRL 5'h19
`define ANC_B_RESTART 9
`define ANC_B_DUPLEX 8
`define ANC_B_ANEN 12
`define ANC_B_SPEED 13
`define ANC_STAT_CONST 16'h7809
`define ANC_B_LINK 2
`define ANC_B_ANDONE 5
`define ANC_LPA_PD100 16'h0081
`define ANC_LPA_PD10 16'h0021
`define ANC_BREAK_MS 1500
`define ANC_CLK_KHZ 125000
`define ANC_BURST_US 16
`define ANC_BURST_CYC ((`ANC_BURST_US * `ANC_CLK_KHZ) / 1000)
`endif

// ---- core/anc_pkg.sv ----
// types shared by the negotiation control block
// assumes anc_regs.svh supplies all numeric constants
package anc_pkg;
    typedef enum logic [2:0] {
        AN_IDLE, AN_BREAK, AN_SEND, AN_DONE, AN_FORCED
    } anc_state_type;
    typedef struct packed {
        logic speed100;
        logic full_dup;
    } anc_mode_type;
    typedef struct packed {
        logic full_dup;
        logic col;
        logic link;
        logic tx_act;
        logic rx_act;
    } anc_led_type;
endpackage

// ---- test/anc_lp_model.sv ----
// link partner across the cable, seen from the negotiation block
// assumes link and page signals are sampled on sys_clk by the block
module anc_lp_model (
    input wire logic sys_clk, // 125 MHz
    input wire logic sys_rst, // async, active high
    input wire logic flp_send, // burst from the device
    input wire logic [15:0] flp_word, // word carried by the burst
    input wire logic tx_quiet, // device silent
    input wire logic [2:0] lp_mode, // 0 off 1 neg 2 100 3 10 4 both
    input wire logic [15:0] lp_word, // our ability word
    input wire logic [7:0] resp_dly, // cycles before answering a burst
    output logic link100_ok, // 100 Mb/s link signals seen
    output logic link10_ok, // 10 Mb/s link signals seen
    output logic page_rx, // page pulse
    output logic [15:0] page_word // page contents
);
    logic pend;
    logic c100;
    logic [7:0] cnt;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            link100_ok <= 1'b0;
            link10_ok <= 1'b0;
            page_rx <= 1'b0;
            page_word <= 16'h0000;
            pend <= 1'b0;
            c100 <= 1'b0;
            cnt <= 8'h00;
        end else begin
            page_rx <= 1'b0;
            // released word goes stale on purpose, inverted the cycle after the page pulse
            if (page_rx) page_word <= ~page_word;
            if (tx_quiet || lp_mode == 3'h0) begin
                link100_ok <= 1'b0; // silence drives us into link fail
                link10_ok <= 1'b0;
                pend <= 1'b0;
            end else if (lp_mode != 3'h1) begin
                link100_ok <= lp_mode != 3'h3; // non-negotiating sender
                link10_ok <= lp_mode != 3'h2;
            end else if (flp_send && !pend) begin
                pend <= 1'b1;
                cnt <= resp_dly;
                c100 <= |(flp_word[8:7] & lp_word[8:7]);
            end else if (pend && cnt != 8'h00) begin
                cnt <= cnt - 8'h01;
            end else if (pend) begin
                pend <= 1'b0;
                page_rx <= 1'b1;
                page_word <= lp_word;
                link100_ok <= c100;
                link10_ok <= !c100;
            end
        end
    end
endmodule

// ---- test/anc_ctrl_tb.sv ----
// self-checking bench for the negotiation and strap block
// assumes mdio has a pull-up and the bench is the management agent
`define CHK(nm, e, g) begin \
    n_tests++; \
    if ((g) !== (e)) begin \
        fail_count++; \
        $display("[FAIL] %s expected %h seen %h", nm, e, g); \
    end \
end
module anc_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIMIT = 90000;
    logic sys_clk, sys_rst, mdc, tb_do, tb_oe, seen_oe;
    logic en_s, a1_s, a0_s, col_s, tx_s, rx_s;
    logic [4:0] strap, phy;
    logic [2:0] lp_mode;
    logic [15:0] lp_word, page_word, flp_word;
    logic [7:0] resp_dly;
    logic mdio_in, mdio_out, mdio_oe, link100_ok, link10_ok, page_rx;
    logic flp_send, tx_quiet, mode_valid, isolate, led_speed;
    anc_pkg::anc_mode_type op_mode;
    anc_pkg::anc_led_type led_out;
    int fail_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int quiet_bad = 0;
    int bursts = 0;
    // released line floats to the pull-up level
    assign mdio_in = mdio_oe ? mdio_out : (tb_oe ? tb_do : 1'b1);
    anc_ctrl #(.BREAK_CYC(200)) i_anc_ctrl (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .address_strap(strap),
        .negotiation_enable_strap(en_s), .advert_strap_high(a1_s),
        .advert_strap_low(a0_s), .mdc(mdc), .mdio_in(mdio_in),
        .mdio_out(mdio_out), .mdio_oe(mdio_oe), .link100_ok(link100_ok),
        .link10_ok(link10_ok), .page_rx(page_rx), .page_word(page_word),
        .led_col_src(col_s), .led_tx_src(tx_s), .led_rx_src(rx_s),
        .flp_send(flp_send), .flp_word(flp_word), .tx_quiet(tx_quiet),
        .op_mode(op_mode), .mode_valid(mode_valid), .isolate(isolate),
        .led_out(led_out), .led_speed(led_speed));
    anc_lp_model i_anc_lp_model (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .flp_send(flp_send), .flp_word(flp_word), .tx_quiet(tx_quiet),
        .lp_mode(lp_mode), .lp_word(lp_word), .resp_dly(resp_dly),
        .link100_ok(link100_ok), .link10_ok(link10_ok),
        .page_rx(page_rx), .page_word(page_word));
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(negedge sys_clk) begin
        if (tx_quiet === 1'b1 && flp_send === 1'b1) quiet_bad++;
        if (flp_send === 1'b1) bursts++;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            fail_count++;
            $display("[FAIL] run time limit reached");
            results();
        end
    end
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // mdc period of 10 clocks, read data sampled away from any edge
    task automatic mdio_bit(input logic v, input logic drv, output logic s);
        @(posedge sys_clk);
        mdc <= 1'b0;
        tb_do <= v;
        tb_oe <= drv;
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
        s = mdio_in;
        seen_oe = seen_oe | mdio_oe;
        @(posedge sys_clk);
        mdc <= 1'b1;
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic frame(input logic [4:0] pa, input logic wr,
        input logic [4:0] rg, input logic [15:0] wd, output logic [15:0] rd);
        logic [15:0] hdr;
        logic s;
        hdr = {2'b01, wr ? 2'b01 : 2'b10, pa, rg, 2'b10};
        repeat (32) mdio_bit(1'b1, 1'b1, s);
        for (int i = 15; i >= 0; i--) mdio_bit(hdr[i], wr || i > 1, s);
        for (int i = 15; i >= 0; i--) begin
            mdio_bit(wd[i], wr, s);
            rd[i] = s;
        end
        @(posedge sys_clk);
        tb_oe <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] rg, input logic [15:0] d);
        logic [15:0] x;
        frame(phy, 1'b1, rg, d, x);
    endtask
    task automatic rd(input logic [4:0] rg, output logic [15:0] d);
        frame(phy, 1'b0, rg, 16'h0000, d);
    endtask
    function automatic logic cond(input int w);
        case (w)
            0: return tx_quiet;
            1: return !tx_quiet;
            2: return flp_send;
            3: return mode_valid;
            default: return flp_send | tx_quiet;
        endcase
    endfunction
    task automatic wait_on(input int w, input int lim, input string nm);
        int n;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (cond(w) !== 1'b1 && n < lim);
        `CHK(nm, 1'b1, cond(w))
    endtask
    task automatic do_reset(input logic [4:0] a, input logic en,
        input logic h, input logic l);
        @(posedge sys_clk);
        strap <= a;
        en_s <= en;
        a1_s <= h;
        a0_s <= l;
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        phy = a;
        repeat (5) @(posedge sys_clk);
    endtask
    task automatic negotiate();
        wr(5'h00, 16'h1200); // restart with speed and duplex clear
        wait_on(0, 100, "quiet");
        `CHK("valid in break", 1'b0, mode_valid)
        wait_on(1, 400, "quiet end");
        wait_on(2, 3000, "burst after break");
        wait_on(3, 20000, "resolved");
    endtask
    task automatic t_straps();
        logic [15:0] d;
        rd(5'h01, d);
        `CHK("status", 16'h7809, d & 16'hFFDB)
        rd(5'h04, d);
        `CHK("advert", 16'h01E1, d)
        seen_oe = 1'b0;
        rd(5'h19, d);
        `CHK("address", phy, d[4:0])
        `CHK("answer", 1'b1, seen_oe)
        `CHK("isolate", 1'b0, isolate)
    endtask
    task automatic t_leds();
        logic [2:0] e, g;
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk);
            {col_s, tx_s, rx_s} <= i[2:0];
            repeat (3) @(negedge sys_clk);
            e = i[2:0] ^ {phy[1], phy[3], phy[4]};
            g = {led_out.col, led_out.tx_act, led_out.rx_act};
            `CHK("led", e, g)
        end
    endtask
    task automatic t_foreign();
        logic [15:0] d;
        seen_oe = 1'b0;
        frame(phy ^ 5'h01, 1'b0, 5'h01, 16'h0000, d);
        `CHK("foreign oe", 1'b0, seen_oe)
        `CHK("foreign data", 16'hFFFF, d)
    endtask
    task automatic t_advert();
        wr(5'h04, 16'h0061);
        wait_on(2, 3000, "burst");
        `CHK("burst word", 16'h0061, flp_word)
    endtask
    task automatic t_forced();
        logic [15:0] d;
        wr(5'h00, 16'h2100);
        wait_on(3, 200, "forced valid");
        `CHK("forced 100 full", 2'b11, op_mode)
        rd(5'h10, d);
        `CHK("forced summary", 2'b10, d[2:1])
        wr(5'h00, 16'h0000);
        rd(5'h10, d);
        `CHK("forced 10 half", 2'b00, op_mode)
        `CHK("summary 10 half", 2'b01, d[2:1])
    endtask
    task automatic t_resolve();
        logic [15:0] adv[4] = '{16'h01E1, 16'h00A1, 16'h0061, 16'h0021};
        logic [15:0] lpw[4] = '{16'h01E1, 16'h01E1, 16'h0141, 16'h01E1};
        logic [1:0] md[4] = '{2'b11, 2'b10, 2'b01, 2'b00};
        logic [15:0] d;
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            lp_mode <= 3'h1;
            lp_word <= lpw[i];
            resp_dly <= 8'(i * 60);
            wr(5'h04, adv[i]);
            negotiate();
            `CHK("mode", md[i], op_mode)
            rd(5'h05, d);
            `CHK("partner", lpw[i], d)
            rd(5'h10, d);
            `CHK("summary", {md[i][0], !md[i][1]}, d[2:1])
            rd(5'h06, d);
            `CHK("able", 1'b1, d[0])
        end
        @(posedge sys_clk);
        lp_mode <= 3'h0;
        wait_on(4, 3000, "link lost");
    endtask
    task automatic t_parallel();
        logic [15:0] ex[2] = '{16'h0081, 16'h0021};
        logic [15:0] d;
        wr(5'h04, 16'h01E1);
        for (int i = 0; i < 2; i++) begin
            @(posedge sys_clk);
            lp_mode <= 3'(2 + i);
            negotiate();
            `CHK("pd mode", {!i[0], 1'b0}, op_mode)
            rd(5'h05, d);
            `CHK("pd partner", ex[i], d)
            rd(5'h06, d);
            `CHK("pd able", 2'b00, {d[4], d[0]})
            rd(5'h01, d);
            `CHK("pd done", 1'b1, d[5])
        end
        @(posedge sys_clk);
        lp_mode <= 3'h4;
        wr(5'h00, 16'h1200);
        d = 16'h0000;
        for (int n = 0; n < 20 && d[4] !== 1'b1; n++) rd(5'h06, d);
        `CHK("pd fault", 1'b1, d[4])
    endtask
    task automatic t_boot();
        int b0;
        do_reset(5'h00, 1'b0, 1'b1, 1'b0);
        `CHK("strap isolate", 1'b1, isolate)
        wait_on(3, 200, "boot valid");
        `CHK("boot mode", 2'b10, op_mode)
        wr(5'h00, 16'h1200);
        b0 = bursts;
        repeat (3000) @(negedge sys_clk);
        `CHK("no bursts", 0, bursts - b0)
        wr(5'h00, 16'h0000);
        wr(5'h00, 16'h1000);
        wait_on(4, 3000, "enabled");
        do_reset(5'h0A, 1'b1, 1'b1, 1'b1);
        wr(5'h19, 16'h0000);
        `CHK("written zero", 1'b0, isolate)
    endtask
    initial begin
        sys_rst = 1'b1;
        mdc = 1'b1;
        tb_do = 1'b1;
        tb_oe = 1'b0;
        seen_oe = 1'b0;
        {en_s, a1_s, a0_s, col_s, tx_s, rx_s} = 6'h38;
        strap = 5'h0A;
        phy = 5'h0A;
        lp_mode = 3'h0;
        lp_word = 16'h0000;
        resp_dly = 8'h00;
        do_reset(5'h0A, 1'b1, 1'b1, 1'b1);
        t_straps();
        t_leds();
        t_foreign();
        t_advert();
        t_forced();
        t_resolve();
        t_parallel();
        t_boot();
        `CHK("pulses while quiet", 0, quiet_bad)
        results();
    end
endmodule
